// *** src/cikh_pkg.sv ***
// Constants for the configuration index/data pair and the keyboard host port.
// Assumes a 16-bit ISA I/O address and an 8-bit data bus.
package cikh_pkg;
  // ----------------------------------------
  // I/O addresses
  // ----------------------------------------
  localparam logic [15:0] IO_CONFIG_INDEX_PORT = 16'h00EC;
  localparam logic [15:0] IO_CONFIG_DATA_PORT = 16'h00ED;
  localparam logic [15:0] IO_KBC_DATA_PORT = 16'h0060;
  localparam logic [15:0] IO_KBC_STATUS_COMMAND_PORT = 16'h0064;
  localparam int KBC_SEL_BIT = 2;
  // ----------------------------------------
  // Index values
  // ----------------------------------------
  localparam logic [7:0] IDX_RTC_DECODE_ADDR_LOW = 8'h1B;
  localparam logic [7:0] IDX_RTC_DECODE_ADDR_HIGH = 8'h1C;
  localparam logic [7:0] IDX_MISC_PIN_MODE_CONTROL = 8'h1D;
  localparam logic [7:0] IDX_SILICON_REVISION = 8'h1F;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_RTC_DECODE_ADDR_LOW = 8'h71;
  localparam logic [7:0] RST_RTC_DECODE_ADDR_HIGH = 8'h00;
  localparam logic [7:0] RST_MISC_PIN_MODE_CONTROL = 8'hC3;
  localparam logic [7:0] RST_INDEX = 8'h00;
  // Arbitrary value, not tied to any part
  localparam logic [7:0] SILICON_REVISION_CODE = 8'hA5;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int LOW_CLOCK_DECODE_ENABLE = 0;
  localparam int MISC_KBD_MODE = 1;
  localparam int MISC_PRIVATE_PIN_FREEZE = 2;
  localparam int MISC_AUX_OUT_FIRST = 3;
  localparam int MISC_AUX_OUT_SECOND = 4;
  localparam int MISC_AUX_PIN_DIRECTION = 5;
  localparam int STAT_OUTPUT_FULL = 0;
  localparam int STAT_INPUT_FULL = 1;
  localparam int STAT_COMMAND_DATA = 3;
endpackage

// *** src/cikh_config_kbc_port.sv ***
// Configuration index/data registers, clock address decode and keyboard host port.
// Assumes ISA strobes and address arrive from pins; microcontroller side is same-clock logic.
//
// What this block does
// (R1) Decode index at ECh, data at EDh
// (R2) Index byte selects register for data port
// (R3) Index write-only, data port read/write
// (R4) Index 1B/1C/1D/1F select the four registers
// (R5) Enabled address match generates clock access
// (R6) Low bits 7:1, high byte bits 15:8
// (R7) Reset low 71h, high 00h
// (R8) Clock ports default to 70h and 71h
// (R9) Misc bit 1 keyboard mode, resets 1
// (R10) Software writes ones to bits 0,6,7
// (R11) Misc bit 2 freezes three private pins
// (R12) Misc bit 5 makes aux pins outputs
// (R13) Bits 3,4 drive aux pins when output
// (R14) Revision register returns fixed code
// (R15) Host port at 60h/64h, A2 selects
// (R16) Data read returns buffer, clears output-full
// (R17) Status read changes no flag
// (R18) Data write loads buffer, C/D=0, input-full
// (R19) Command write loads buffer, C/D=1, input-full
// (R20) Controller load sets output-full
// (R21) Controller read clears input-full
// (R22) Host select decodes address with strobes
// (R23) Config register defaults applied while system reset asserted
// (R24) Unimplemented index: write ignored, stable read
`timescale 1ns/1ps
`default_nettype none
module cikh_config_kbc_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic system_reset_in,
  // ISA host side
  input wire logic [15:0] io_addr,
  input wire logic io_rd_b,
  input wire logic io_wr_b,
  input wire logic [7:0] sd_in,
  output logic [7:0] sd_out,
  output logic sd_oe,
  // Clock core selects
  output logic clock_access,
  // Microcontroller side
  input wire logic mcu_out_load,
  input wire logic [7:0] mcu_out_data,
  input wire logic mcu_in_read,
  input wire logic [3:0] mcu_status_upper,
  input wire logic mcu_status_sys,
  output logic [7:0] host_in_buffer,
  output logic kbd_mode,
  output logic [7:0] status_byte,
  // Private pins, controller drives and freeze applied here
  input wire logic speed_select_in,
  input wire logic shadow_ram_in,
  input wire logic mouse_irq_in,
  output logic speed_select_pin,
  output logic shadow_ram_pin,
  output logic mouse_irq_pin,
  // Auxiliary pins
  input wire logic aux_pin_first_in,
  input wire logic aux_pin_second_in,
  output logic aux_pin_first_out,
  output logic aux_pin_second_out,
  output logic aux_pin_first_oe,
  output logic aux_pin_second_oe,
  output logic [1:0] aux_port1_bits
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [15:0] addr_s1_r, addr_s2_r;
  logic rd_s1_r, rd_s2_r, rd_s3_r, wr_s1_r, wr_s2_r, wr_s3_r;
  logic [7:0] sd_s1_r, sd_s2_r;
  logic rst_s1_r, rst_s2_r;
  logic [1:0] aux_s1_r, aux_s2_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_s1_r <= 16'h0000;
      addr_s2_r <= 16'h0000;
      rd_s1_r <= 1'b1;
      rd_s2_r <= 1'b1;
      rd_s3_r <= 1'b1;
      wr_s1_r <= 1'b1;
      wr_s2_r <= 1'b1;
      wr_s3_r <= 1'b1;
      sd_s1_r <= 8'h00;
      sd_s2_r <= 8'h00;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
      aux_s1_r <= 2'h0;
      aux_s2_r <= 2'h0;
    end else begin
      addr_s1_r <= io_addr;
      addr_s2_r <= addr_s1_r;
      rd_s1_r <= io_rd_b;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
      wr_s1_r <= io_wr_b;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      sd_s1_r <= sd_in;
      sd_s2_r <= sd_s1_r;
      rst_s1_r <= system_reset_in;
      rst_s2_r <= rst_s1_r;
      aux_s1_r <= {aux_pin_second_in, aux_pin_first_in};
      aux_s2_r <= aux_s1_r;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Act once per strobe, on its falling edge after sync; holds no side effect for long strobes
  logic rd_lvl, rd_start, wr_start;
  assign rd_lvl = !rd_s2_r;
  assign rd_start = !rd_s2_r && rd_s3_r;
  assign wr_start = !wr_s2_r && wr_s3_r;

  logic sel_index, sel_data, sel_kbc, kbc_cmd;
  assign sel_index = (addr_s2_r == cikh_pkg::IO_CONFIG_INDEX_PORT); // see (R1)
  assign sel_data = (addr_s2_r == cikh_pkg::IO_CONFIG_DATA_PORT); // see (R1)
  // Both host ports differ only in A2
  assign sel_kbc = ((addr_s2_r & ~(16'h0001 << cikh_pkg::KBC_SEL_BIT)) == cikh_pkg::IO_KBC_DATA_PORT); // see (R15) (R22)
  assign kbc_cmd = addr_s2_r[cikh_pkg::KBC_SEL_BIT]; // see (R15)

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] index_r, low_r, high_r, misc_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      index_r <= cikh_pkg::RST_INDEX;
    end else if (rst_s2_r) begin
      index_r <= cikh_pkg::RST_INDEX;
    end else if (wr_start && sel_index) begin
      index_r <= sd_s2_r; // see (R2) (R3)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_r <= cikh_pkg::RST_RTC_DECODE_ADDR_LOW; // see (R7) (R8)
      high_r <= cikh_pkg::RST_RTC_DECODE_ADDR_HIGH;
      misc_r <= cikh_pkg::RST_MISC_PIN_MODE_CONTROL; // see (R9) (R11) (R12)
    end else if (rst_s2_r) begin
      low_r <= cikh_pkg::RST_RTC_DECODE_ADDR_LOW; // see (R23)
      high_r <= cikh_pkg::RST_RTC_DECODE_ADDR_HIGH;
      misc_r <= cikh_pkg::RST_MISC_PIN_MODE_CONTROL;
    end else if (wr_start && sel_data) begin
      // Other indexes, revision included, drop the write
      unique case (index_r) // see (R4) (R24)
        cikh_pkg::IDX_RTC_DECODE_ADDR_LOW: low_r <= sd_s2_r;
        cikh_pkg::IDX_RTC_DECODE_ADDR_HIGH: high_r <= sd_s2_r;
        cikh_pkg::IDX_MISC_PIN_MODE_CONTROL: misc_r <= sd_s2_r; // see (R10)
        default: ;
      endcase
    end
  end

  logic [7:0] cfg_rd;
  always_comb begin
    unique case (index_r) // see (R2) (R4)
      cikh_pkg::IDX_RTC_DECODE_ADDR_LOW: cfg_rd = low_r;
      cikh_pkg::IDX_RTC_DECODE_ADDR_HIGH: cfg_rd = high_r;
      cikh_pkg::IDX_MISC_PIN_MODE_CONTROL: cfg_rd = misc_r;
      cikh_pkg::IDX_SILICON_REVISION: cfg_rd = cikh_pkg::SILICON_REVISION_CODE; // see (R14)
      default: cfg_rd = 8'hFF; // see (R24)
    endcase
  end

  // ----------------------------------------
  // Clock core address match
  // ----------------------------------------
  // Bit 0 of the pin address is not compared
  assign clock_access = low_r[cikh_pkg::LOW_CLOCK_DECODE_ENABLE] && (rd_lvl || !wr_s2_r)
    && (addr_s2_r[15:1] == {high_r, low_r[7:1]}); // see (R5) (R6) (R8)

  // ----------------------------------------
  // Keyboard host port
  // ----------------------------------------
  logic [7:0] out_buf_r, in_buf_r;
  logic obf_r, ibf_r, cd_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_buf_r <= 8'h00;
    end else if (mcu_out_load) begin
      out_buf_r <= mcu_out_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      obf_r <= 1'b0;
    end else if (mcu_out_load) begin
      obf_r <= 1'b1; // see (R20)
    end else if (rd_start && sel_kbc && !kbc_cmd) begin
      obf_r <= 1'b0; // see (R16)
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_buf_r <= 8'h00;
      cd_r <= 1'b0;
    end else if (wr_start && sel_kbc) begin
      in_buf_r <= sd_s2_r; // see (R18) (R19)
      cd_r <= kbc_cmd;
    end
  end

  // Host write wins over a same-cycle controller read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ibf_r <= 1'b0;
    end else if (wr_start && sel_kbc) begin
      ibf_r <= 1'b1; // see (R18) (R19)
    end else if (mcu_in_read) begin
      ibf_r <= 1'b0; // see (R21)
    end
  end

  always_comb begin
    status_byte = {mcu_status_upper, 4'h0};
    status_byte[cikh_pkg::STAT_OUTPUT_FULL] = obf_r;
    status_byte[cikh_pkg::STAT_INPUT_FULL] = ibf_r;
    status_byte[2] = mcu_status_sys;
    status_byte[cikh_pkg::STAT_COMMAND_DATA] = cd_r;
  end
  assign host_in_buffer = in_buf_r;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_out <= 8'h00;
      sd_oe <= 1'b0;
    end else if (rd_lvl && sel_data) begin
      sd_out <= cfg_rd; // see (R3)
      sd_oe <= 1'b1;
    end else if (rd_lvl && sel_kbc) begin
      sd_out <= kbc_cmd ? status_byte : out_buf_r; // see (R16) (R17)
      sd_oe <= 1'b1;
    end else begin
      sd_oe <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pins steered by the control register
  // ----------------------------------------
  assign kbd_mode = misc_r[cikh_pkg::MISC_KBD_MODE]; // see (R9)

  logic [2:0] priv_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      priv_r <= 3'h0;
    end else if (!misc_r[cikh_pkg::MISC_PRIVATE_PIN_FREEZE]) begin
      priv_r <= {mouse_irq_in, shadow_ram_in, speed_select_in}; // see (R11)
    end
  end
  assign speed_select_pin = priv_r[0];
  assign shadow_ram_pin = priv_r[1];
  assign mouse_irq_pin = priv_r[2];

  assign aux_pin_first_oe = misc_r[cikh_pkg::MISC_AUX_PIN_DIRECTION]; // see (R12)
  assign aux_pin_second_oe = misc_r[cikh_pkg::MISC_AUX_PIN_DIRECTION];
  assign aux_pin_first_out = misc_r[cikh_pkg::MISC_AUX_OUT_FIRST]; // see (R13)
  assign aux_pin_second_out = misc_r[cikh_pkg::MISC_AUX_OUT_SECOND];
  assign aux_port1_bits = aux_s2_r; // see (R12)
endmodule
`default_nettype wire

// *** test/cikh_config_kbc_port_chk.sv ***
// Assertions on host strobes, status flags and pins.
// Assumes the host holds each strobe 6 clocks.
`timescale 1ns/1ps
`default_nettype none
module cikh_config_kbc_port_chk (
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] io_addr,
  input wire logic io_rd_b,
  input wire logic io_wr_b,
  input wire logic sd_oe,
  input wire logic mcu_out_load,
  input wire logic mcu_in_read,
  input wire logic [3:0] mcu_status_upper,
  input wire logic mcu_status_sys,
  input wire logic [7:0] status_byte,
  input wire logic speed_select_in,
  input wire logic speed_select_pin,
  input wire logic aux_pin_first_oe,
  input wire logic aux_pin_second_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence host_wr_s;
    $fell(io_wr_b) ##1 !io_wr_b [*2];
  endsequence
  sequence kbc_addr_s;
    io_addr[15:3] == 13'h000C && io_addr[1:0] == 2'h0;
  endsequence
  AST_AUX_OE: assert property (aux_pin_first_oe == aux_pin_second_oe)
    else $error("aux enables differ");
  AST_OBF_SET: assert property (mcu_out_load |=> status_byte[0])
    else $error("output full not set");
  AST_IBF_CLR: assert property (mcu_in_read && io_wr_b && $past(io_wr_b) && $past(io_wr_b, 2)
    && $past(io_wr_b, 3) |=> !status_byte[1]) else $error("input full not cleared");
  AST_STAT_MAP: assert property (status_byte[7:4] == mcu_status_upper && status_byte[2] == mcu_status_sys)
    else $error("status byte mismatch");
  AST_OBF_CLR: assert property ($fell(status_byte[0]) |-> !$past(io_rd_b, 3) && !$past(io_addr[2], 3))
    else $error("output full cleared without data read");
  AST_SD_OE: assert property (sd_oe |-> !(io_rd_b && $past(io_rd_b) && $past(io_rd_b, 2)
    && $past(io_rd_b, 3) && $past(io_rd_b, 4) && $past(io_rd_b, 5))) else $error("drive without read");
  AST_PRIV: assert property ($changed(speed_select_pin) |-> speed_select_pin == $past(speed_select_in))
    else $error("speed pin changed wrongly");
  AST_KBC_WR: assert property (host_wr_s ##0 kbc_addr_s |-> ##[1:3]
    (status_byte[1] && status_byte[3] == io_addr[2])) else $error("host write flags wrong");
endmodule
bind cikh_config_kbc_port cikh_config_kbc_port_chk u_chk (.ref_clk, .rst_b, .io_addr, .io_rd_b, .io_wr_b,
  .sd_oe, .mcu_out_load, .mcu_in_read, .mcu_status_upper, .mcu_status_sys, .status_byte,
  .speed_select_in, .speed_select_pin, .aux_pin_first_oe, .aux_pin_second_oe);
`default_nettype wire

// *** test/cikh_host.sv ***
// ISA host model issuing one I/O cycle per call.
// Assumes the bench calls acc from one process only.
`timescale 1ns/1ps
`default_nettype none
module cikh_host (
  // Bus
  input wire logic ref_clk,
  input wire logic [7:0] sd_out,
  input wire logic clock_access,
  output logic [15:0] io_addr,
  output logic io_rd_b,
  output logic io_wr_b,
  output logic [7:0] sd_in
);
  initial begin
    io_addr = 16'hFFFF;
    io_rd_b = 1'b1;
    io_wr_b = 1'b1;
    sd_in = 8'h00;
  end
  // Six clocks low and high: the pins pass a 2-stage sync
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ca);
    @(posedge ref_clk);
    io_addr <= a;
    sd_in <= d;
    repeat (3) @(posedge ref_clk);
    if (wr) io_wr_b <= 1'b0;
    else io_rd_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    q = sd_out;
    ca = clock_access;
    io_wr_b <= 1'b1;
    io_rd_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    io_addr <= ~a;
    sd_in <= ~d;
  endtask
endmodule
`default_nettype wire

// *** test/config_index_and_kbc_host_port_bench.sv ***
// Self-checking bench for the config and keyboard host port block.
// Assumes cikh_host drives the ISA side.
`timescale 1ns/1ps
`default_nettype none
module config_index_and_kbc_host_port_bench;
  logic ref_clk = 1'b0, rst_b = 1'b0, system_reset_in = 1'b0, mcu_out_load = 1'b0, mcu_in_read = 1'b0;
  logic speed_select_in = 1'b0, io_rd_b, io_wr_b, sd_oe, clock_access, kbd_mode, speed_select_pin, ca;
  logic shadow_ram_pin, mouse_irq_pin;
  logic aux_pin_first_out, aux_pin_second_out, aux_pin_first_oe, aux_pin_second_oe;
  logic [7:0] mcu_out_data = 8'h00, sd_in, sd_out, host_in_buffer, status_byte, q;
  logic [1:0] aux_in = 2'b10, aux_port1_bits;
  logic [15:0] io_addr;
  int miscompares = 0, tests_run = 0, cycles = 0;
  cikh_config_kbc_port DUT (.ref_clk, .rst_b, .system_reset_in, .io_addr, .io_rd_b, .io_wr_b, .sd_in,
    .sd_out, .sd_oe, .clock_access, .mcu_out_load, .mcu_out_data, .mcu_in_read, .mcu_status_upper(4'hA),
    .mcu_status_sys(1'b1), .host_in_buffer, .kbd_mode, .status_byte, .speed_select_in,
    .shadow_ram_in(speed_select_in), .mouse_irq_in(speed_select_in), .speed_select_pin, .shadow_ram_pin,
    .mouse_irq_pin, .aux_pin_first_in(aux_in[0]),
    .aux_pin_second_in(aux_in[1]), .aux_pin_first_out, .aux_pin_second_out, .aux_pin_first_oe,
    .aux_pin_second_oe, .aux_port1_bits);
  cikh_host u_host (.ref_clk, .sd_out, .clock_access, .io_addr, .io_rd_b, .io_wr_b, .sd_in);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q, ca);
  endtask
  task automatic rd(input logic [15:0] a);
    u_host.acc(1'b0, a, 8'h00, q, ca);
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(cikh_pkg::IO_CONFIG_INDEX_PORT, i);
    wr(cikh_pkg::IO_CONFIG_DATA_PORT, d);
  endtask
  task automatic reg_chk(input logic [7:0] i, input logic [7:0] e);
    wr(cikh_pkg::IO_CONFIG_INDEX_PORT, i);
    rd(cikh_pkg::IO_CONFIG_DATA_PORT);
    chk(q, e);
  endtask
  task automatic t_reset();
    reg_chk(8'h1B, 8'h71);
    reg_chk(8'h1C, 8'h00);
    reg_chk(8'h1D, 8'hC3);
    reg_wr(8'h1F, 8'h00);
    reg_chk(8'h1F, cikh_pkg::SILICON_REVISION_CODE);
    // Index port read must not drive, so the last read byte stays
    rd(cikh_pkg::IO_CONFIG_INDEX_PORT);
    chk(q, cikh_pkg::SILICON_REVISION_CODE);
    reg_wr(8'h1E, 8'h12);
    reg_chk(8'h1E, 8'hFF);
    chk({kbd_mode, aux_pin_first_oe, aux_port1_bits}, 4'hA);
  endtask
  task automatic t_clock();
    rd(16'h0071);
    chk(ca, 1'b1);
    rd(16'h0072);
    chk(ca, 1'b0);
    reg_wr(8'h1C, 8'h12);
    reg_wr(8'h1B, 8'h35);
    rd(16'h1234);
    chk(ca, 1'b1);
    reg_wr(8'h1B, 8'h34);
    rd(16'h1234);
    chk(ca, 1'b0);
  endtask
  task automatic t_misc();
    speed_select_in <= 1'b1;
    reg_wr(8'h1D, 8'hE9);
    chk({kbd_mode, aux_pin_second_out, aux_pin_first_out, aux_pin_first_oe}, 4'h3);
    reg_chk(8'h1D, 8'hE9);
    reg_wr(8'h1D, 8'hF5);
    speed_select_in <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({aux_pin_second_out, aux_pin_first_out, speed_select_pin, shadow_ram_pin, mouse_irq_pin}, 5'h17);
    reg_wr(8'h1D, 8'hE9);
    chk({speed_select_pin, shadow_ram_pin, mouse_irq_pin}, 3'h0);
    system_reset_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    system_reset_in <= 1'b0;
    reg_chk(8'h1D, 8'hC3);
    reg_chk(8'h1B, 8'h71);
  endtask
  task automatic t_kbc();
    mcu_out_load <= 1'b1;
    mcu_out_data <= 8'h5A;
    @(posedge ref_clk);
    mcu_out_load <= 1'b0;
    rd(cikh_pkg::IO_KBC_STATUS_COMMAND_PORT);
    rd(cikh_pkg::IO_KBC_STATUS_COMMAND_PORT);
    chk(q, 8'hA5);
    rd(cikh_pkg::IO_KBC_DATA_PORT);
    chk({q, status_byte}, 16'h5AA4);
    wr(cikh_pkg::IO_KBC_DATA_PORT, 8'h11);
    chk({status_byte, host_in_buffer}, 16'hA611);
    mcu_in_read <= 1'b1;
    @(posedge ref_clk);
    mcu_in_read <= 1'b0;
    @(posedge ref_clk);
    chk(status_byte[1], 1'b0);
    wr(cikh_pkg::IO_KBC_STATUS_COMMAND_PORT, 8'hD4);
    wr(16'h0160, 8'h77);
    chk({status_byte, host_in_buffer}, 16'hAED4);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Run needs about 710 clocks
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_clock();
    t_misc();
    t_kbc();
    results();
  end
endmodule
`default_nettype wire
